// >>> hw/ptu_pkg.sv
package ptu_pkg;
  localparam logic [31:0] PTU_OFS_CTRL       = 32'h0000_0000;
  localparam logic [31:0] PTU_OFS_DIRBASE    = 32'h0000_0004;
  localparam logic [31:0] PTU_OFS_FLTADDR    = 32'h0000_0008;
  localparam logic [31:0] PTU_OFS_FLTCODE    = 32'h0000_000C;
  localparam logic [31:0] PTU_OFS_FLTRET     = 32'h0000_0010;
  localparam logic [31:0] PTU_OFS_STATUS     = 32'h0000_0014;
  localparam logic [31:0] PTU_CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] PTU_DIRBASE_RESET  = 32'h0000_0000;
  localparam int          PTU_CTRL_PG        = 0;
  localparam int          PTU_VPN_LSB        = 12;
  localparam int          PTU_DIR_LSB        = 22;
  localparam int          PTU_E_P            = 0;
  localparam int          PTU_E_RW           = 1;
  localparam int          PTU_E_US           = 2;
  localparam int          PTU_E_A            = 5;
  localparam int          PTU_E_D            = 6;
  localparam int          PTU_EC_P           = 0;
  localparam int          PTU_EC_WR          = 1;
  localparam int          PTU_EC_US          = 2;
  localparam int          PTU_HTRANS_ACTIVE  = 1;
  localparam logic [31:0] PTU_V86_MASK       = 32'h000F_FFFF;
  localparam logic [7:0]  PTU_VEC_PAGE_FAULT = 8'h0E;
  localparam logic        PTU_HRESP_OKAY     = 1'b0;
  localparam int          PTU_TLB_SETS       = 8;
  localparam int          PTU_TLB_WAYS       = 4;

  typedef enum logic [2:0] {
    PTU_S_IDLE   = 3'h0,
    PTU_S_LOOK   = 3'h1,
    PTU_S_PDE_RD = 3'h3,
    PTU_S_PDE_WR = 3'h2,
    PTU_S_PTE_RD = 3'h6,
    PTU_S_PTE_WR = 3'h7,
    PTU_S_OPER   = 3'h5,
    PTU_S_FAULT  = 3'h4
  } ptu_state_e;
endpackage

// >>> hw/ptu_tlb.sv
`timescale 1ns/100ps
module ptu_tlb #(
  parameter int SETS = 8,
  parameter int WAYS = 4,
  parameter int IB   = $clog2(SETS),
  parameter int WB   = $clog2(WAYS)
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic [19:0]   lookVpn,
  output logic               lookHit,
  output logic [WB-1:0]      lookWay,
  output logic [19:0]        lookFrame,
  output logic               lookUser,
  output logic               lookRw,
  output logic               lookDirty,
  output logic [WB-1:0]      victimWay,
  output logic               anyValid,
  input  wire logic          fillEn,
  input  wire logic [WB-1:0] fillWay,
  input  wire logic [19:0]   fillVpn,
  input  wire logic [19:0]   fillFrame,
  input  wire logic          fillUser,
  input  wire logic          fillRw,
  input  wire logic          fillDirty,
  input  wire logic          flush
);
  localparam int N  = SETS * WAYS;
  localparam int EB = IB + WB;

  logic [N-1:0]     valid;
  logic [19-IB:0]   tagMem   [N];
  logic [19:0]      frameMem [N];
  logic [2:0]       attrMem  [N];
  logic [WB-1:0]    rrWay;
  logic             freeFound;
  logic [WB-1:0]    freeWay;

  function automatic logic [EB-1:0] slot(input logic [19:0] vpn,
                                         input int w);
    return {vpn[IB-1:0], WB'(w)};
  endfunction

  assign anyValid = |valid;

  // Only the indexed set is searched; the other sets cannot hold the page
  always_comb begin
    lookHit   = 1'b0;
    lookWay   = '0;
    lookFrame = '0;
    lookUser  = 1'b0;
    lookRw    = 1'b0;
    lookDirty = 1'b0;
    for (int w = 0; w < WAYS; w++) begin
      if (valid[slot(lookVpn, w)] &&
          tagMem[slot(lookVpn, w)] == lookVpn[19:IB]) begin
        lookHit   = 1'b1;
        lookWay   = WB'(w);
        lookFrame = frameMem[slot(lookVpn, w)];
        {lookUser, lookRw, lookDirty} = attrMem[slot(lookVpn, w)];
      end
    end
  end

  // Empty way first, otherwise round robin
  always_comb begin
    freeFound = 1'b0;
    freeWay   = '0;
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (!valid[slot(fillVpn, w)]) begin
        freeFound = 1'b1;
        freeWay   = WB'(w);
      end
    end
  end

  assign victimWay = freeFound ? freeWay : rrWay;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valid <= '0;
      rrWay <= '0;
    end else if (flush) begin
      valid <= '0;
    end else if (fillEn) begin
      valid[{fillVpn[IB-1:0], fillWay}] <= 1'b1;
      rrWay <= rrWay + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (fillEn) begin
      tagMem[{fillVpn[IB-1:0], fillWay}]   <= fillVpn[19:IB];
      frameMem[{fillVpn[IB-1:0], fillWay}] <= fillFrame;
      attrMem[{fillVpn[IB-1:0], fillWay}]  <= {fillUser, fillRw, fillDirty};
    end
  end
endmodule

// >>> hw/ptu_page_translation_unit.sv
`timescale 1ns/100ps
module ptu_page_translation_unit (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        reqValid,
  input  wire logic [31:0] reqLinAddr,
  input  wire logic        reqWrite,
  input  wire logic        reqUser,
  input  wire logic        reqDescriptor,
  input  wire logic        reqV86,
  input  wire logic [31:0] reqInstrPtr,
  output logic             reqReady,
  output logic             doneValid,
  output logic [31:0]      donePhysAddr,
  input  wire logic        taskSwitch,
  input  wire logic [31:0] taskStateDirBase,
  input  wire logic        handlerEntry,
  output logic             memReq,
  output logic [31:0]      memAddr,
  output logic             memWrite,
  output logic             memLock,
  output logic             memOperand,
  output logic [31:0]      memWdata,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata,
  output logic             faultValid,
  output logic [7:0]       faultVector,
  output logic [15:0]      faultErrorCode,
  output logic [31:0]      faultReturnPointer,
  output logic             faultNested
);
  import ptu_pkg::*;

  localparam int WB = $clog2(PTU_TLB_WAYS);

  ptu_state_e    state;
  ptu_state_e    next_state;
  logic [31:0]   ctrl;
  logic [31:0]   directoryBase;
  logic [31:0]   faultLinearAddress;
  logic [31:0]   linAddr;
  logic [31:0]   instrPtr;
  logic          accWrite;
  logic          accUser;
  logic          accDesc;
  logic [31:0]   pdeVal;
  logic [31:0]   pteVal;
  logic          lookHitSaved;
  logic [WB-1:0] lookWaySaved;
  logic          dWrite;
  logic [31:0]   dAddr;

  logic          tlbHit;
  logic [WB-1:0] tlbWay;
  logic [19:0]   tlbFrame;
  logic          tlbUser;
  logic          tlbRw;
  logic          tlbDirty;
  logic [WB-1:0] tlbVictim;
  logic          tlbAnyValid;
  logic          tlbFill;

  logic          takeReq;
  logic          ahbTake;
  logic          flush;
  logic          pagingOn;
  logic          effUser;
  logic [31:0]   effLin;
  logic          hitOk;
  logic          hitViol;
  logic          entryPresent;
  logic          walkUser;
  logic          walkRw;
  logic          walkViol;
  logic [31:0]   pdeAddr;
  logic [31:0]   pteAddr;
  logic [31:0]   hitPhys;
  logic [31:0]   walkPhys;
  logic [31:0]   readMux;
  logic          next_prot;
  logic [15:0]   next_code;
  logic          next_isMem;
  logic [31:0]   next_memAddr;
  logic [31:0]   next_memWdata;

  // Supervisor accesses bypass page protection
  function automatic logic protViol(input logic pgUser, input logic pgRw,
                                    input logic isUser, input logic isWr);
    return isUser && (!pgUser || (isWr && !pgRw));
  endfunction

  ptu_tlb #(
    .SETS (PTU_TLB_SETS),
    .WAYS (PTU_TLB_WAYS)
  ) u_tlb (
    .clk       (clk),
    .reset_n   (reset_n),
    .lookVpn   (linAddr[31:PTU_VPN_LSB]),
    .lookHit   (tlbHit),
    .lookWay   (tlbWay),
    .lookFrame (tlbFrame),
    .lookUser  (tlbUser),
    .lookRw    (tlbRw),
    .lookDirty (tlbDirty),
    .victimWay (tlbVictim),
    .anyValid  (tlbAnyValid),
    .fillEn    (tlbFill),
    .fillWay   (lookHitSaved ? lookWaySaved : tlbVictim),
    .fillVpn   (linAddr[31:PTU_VPN_LSB]),
    .fillFrame (pteVal[31:PTU_VPN_LSB]),
    .fillUser  (pdeVal[PTU_E_US] & pteVal[PTU_E_US]),
    .fillRw    (pdeVal[PTU_E_RW] & pteVal[PTU_E_RW]),
    .fillDirty (pteVal[PTU_E_D] | accWrite),
    .flush     (flush)
  );

  assign takeReq  = reqValid && reqReady;
  assign ahbTake  = hsel && htrans[PTU_HTRANS_ACTIVE] && hready;
  // Hardware never watches table writes, so software flushes after edits
  assign flush    = (dWrite && dAddr == PTU_OFS_DIRBASE) ||
                    taskSwitch;
  assign pagingOn = ctrl[PTU_CTRL_PG];
  assign effUser  = accUser && !accDesc;
  assign effLin   = reqV86 ? (reqLinAddr & PTU_V86_MASK)
                           : reqLinAddr;
  // A write through a clean entry walks again to set the dirty flag
  assign hitOk    = tlbHit && !(accWrite && !tlbDirty);
  assign hitViol  = protViol(tlbUser, tlbRw, effUser, accWrite);
  assign entryPresent = memRdata[PTU_E_P];
  assign walkUser = pdeVal[PTU_E_US] & memRdata[PTU_E_US];
  assign walkRw   = pdeVal[PTU_E_RW] & memRdata[PTU_E_RW];
  assign walkViol = protViol(walkUser, walkRw, effUser, accWrite);
  assign pdeAddr  = {directoryBase[31:PTU_VPN_LSB],
                     linAddr[31:PTU_DIR_LSB], 2'h0};
  assign pteAddr  = {pdeVal[31:PTU_VPN_LSB],
                     linAddr[PTU_DIR_LSB-1:PTU_VPN_LSB], 2'h0};
  assign hitPhys  = {tlbFrame, linAddr[PTU_VPN_LSB-1:0]};
  assign walkPhys = {pteVal[31:PTU_VPN_LSB],
                     linAddr[PTU_VPN_LSB-1:0]};
  assign tlbFill  = state == PTU_S_PTE_WR && memAck;

  assign readMux =
    haddr == PTU_OFS_CTRL    ? ctrl :
    haddr == PTU_OFS_DIRBASE ? directoryBase :
    haddr == PTU_OFS_FLTADDR ? faultLinearAddress :
    haddr == PTU_OFS_FLTCODE ? {16'h0000, faultErrorCode} :
    haddr == PTU_OFS_FLTRET  ? faultReturnPointer :
    haddr == PTU_OFS_STATUS  ? {28'h0000000, tlbAnyValid, state} :
                               32'h0000_0000;

  always_comb begin
    next_state = state;
    next_prot  = 1'b0;
    case (state)
      PTU_S_IDLE: begin
        if (takeReq) begin
          next_state = PTU_S_LOOK;
        end
      end
      PTU_S_LOOK: begin
        if (!pagingOn) begin
          next_state = PTU_S_OPER;
        end else if (hitOk && hitViol) begin
          next_state = PTU_S_FAULT;
          next_prot  = 1'b1;
        end else if (hitOk) begin
          next_state = PTU_S_OPER;
        end else begin
          next_state = PTU_S_PDE_RD;
        end
      end
      PTU_S_PDE_RD: begin
        if (memAck) begin
          next_state = entryPresent ? PTU_S_PDE_WR
                                    : PTU_S_FAULT;
        end
      end
      PTU_S_PDE_WR: begin
        if (memAck) begin
          next_state = PTU_S_PTE_RD;
        end
      end
      PTU_S_PTE_RD: begin
        if (memAck && !entryPresent) begin
          next_state = PTU_S_FAULT;
        end else if (memAck && walkViol) begin
          next_state = PTU_S_FAULT;
          next_prot  = 1'b1;
        end else if (memAck) begin
          next_state = PTU_S_PTE_WR;
        end
      end
      PTU_S_PTE_WR: begin
        if (memAck) begin
          next_state = PTU_S_OPER;
        end
      end
      PTU_S_OPER: begin
        if (memAck) begin
          next_state = PTU_S_IDLE;
        end
      end
      PTU_S_FAULT: begin
        next_state = PTU_S_IDLE;
      end
      default: begin
        next_state = PTU_S_IDLE;
      end
    endcase
  end

  always_comb begin
    next_code = '0;
    next_code[PTU_EC_P]  = next_prot;
    next_code[PTU_EC_WR] = accWrite;
    next_code[PTU_EC_US] = effUser;
  end

  assign next_isMem = next_state inside {PTU_S_PDE_RD, PTU_S_PDE_WR,
                                         PTU_S_PTE_RD, PTU_S_PTE_WR,
                                         PTU_S_OPER};
  assign next_memAddr =
    next_state == PTU_S_PDE_RD ? pdeAddr :
    next_state == PTU_S_PDE_WR ? pdeAddr :
    next_state == PTU_S_PTE_RD ? pteAddr :
    next_state == PTU_S_PTE_WR ? pteAddr :
    !pagingOn                  ? linAddr :
    state == PTU_S_LOOK        ? hitPhys : walkPhys;
  // Write-back is the entry just read with the flags merged in
  assign next_memWdata =
    next_state == PTU_S_PDE_WR ? memRdata | (32'h1 << PTU_E_A) :
    next_state == PTU_S_PTE_WR ? memRdata | (32'h1 << PTU_E_A) |
                                 ({31'h0, accWrite} << PTU_E_D) :
                                 32'h0000_0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= PTU_S_IDLE;
      reqReady   <= 1'b1;
      memReq     <= 1'b0;
      memAddr    <= 32'h0000_0000;
      memWrite   <= 1'b0;
      memLock    <= 1'b0;
      memOperand <= 1'b0;
      memWdata   <= 32'h0000_0000;
    end else begin
      state      <= next_state;
      reqReady   <= next_state == PTU_S_IDLE;
      memReq     <= next_isMem;
      memAddr    <= next_memAddr;
      memWrite   <= next_state inside {PTU_S_PDE_WR, PTU_S_PTE_WR} ||
                    (next_state == PTU_S_OPER && accWrite);
      memLock    <= next_state inside {PTU_S_PDE_RD, PTU_S_PDE_WR,
                                       PTU_S_PTE_RD,
                                       PTU_S_PTE_WR};
      memOperand <= next_state == PTU_S_OPER;
      memWdata   <= next_memWdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linAddr      <= 32'h0000_0000;
      instrPtr     <= 32'h0000_0000;
      accWrite     <= 1'b0;
      accUser      <= 1'b0;
      accDesc      <= 1'b0;
      pdeVal       <= 32'h0000_0000;
      pteVal       <= 32'h0000_0000;
      lookHitSaved <= 1'b0;
      lookWaySaved <= '0;
    end else begin
      if (takeReq) begin
        linAddr  <= effLin;
        instrPtr <= reqInstrPtr;
        accWrite <= reqWrite;
        accUser  <= reqUser;
        accDesc  <= reqDescriptor;
      end
      if (state == PTU_S_LOOK) begin
        lookHitSaved <= tlbHit;
        lookWaySaved <= tlbWay;
      end
      if (state == PTU_S_PDE_RD && memAck) begin
        pdeVal <= memRdata;
      end
      if (state == PTU_S_PTE_RD && memAck) begin
        pteVal <= memRdata;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      doneValid          <= 1'b0;
      donePhysAddr       <= 32'h0000_0000;
      faultValid         <= 1'b0;
      faultVector        <= 8'h00;
      faultErrorCode     <= 16'h0000;
      faultReturnPointer <= 32'h0000_0000;
      faultNested        <= 1'b0;
      faultLinearAddress <= 32'h0000_0000;
    end else begin
      doneValid <= state == PTU_S_OPER && memAck;
      if (state == PTU_S_OPER && memAck) begin
        donePhysAddr <= memAddr;
      end
      faultValid <= next_state == PTU_S_FAULT;
      if (next_state == PTU_S_FAULT) begin
        // A fault during handler entry reuses vector 14, not a double fault
        faultVector        <= PTU_VEC_PAGE_FAULT;
        faultNested        <= handlerEntry;
        faultErrorCode     <= next_code;
        faultReturnPointer <= instrPtr;
        faultLinearAddress <= linAddr;
      end
    end
  end

  // Zero-wait slave; a read right after a write sees the old value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout     <= 1'b1;
      hresp         <= PTU_HRESP_OKAY;
      hrdata        <= 32'h0000_0000;
      dWrite        <= 1'b0;
      dAddr         <= 32'h0000_0000;
      ctrl          <= PTU_CTRL_RESET;
      directoryBase <= PTU_DIRBASE_RESET;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= PTU_HRESP_OKAY;
      hrdata    <= (ahbTake && !hwrite) ? readMux : 32'h0000_0000;
      dWrite    <= ahbTake && hwrite;
      dAddr     <= haddr;
      if (taskSwitch) begin
        directoryBase <= {taskStateDirBase[31:PTU_VPN_LSB],
                          12'h000};
      end else if (dWrite && dAddr == PTU_OFS_DIRBASE) begin
        directoryBase <= {hwdata[31:PTU_VPN_LSB], 12'h000};
      end
      if (dWrite && dAddr == PTU_OFS_CTRL) begin
        ctrl <= hwdata;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence sDirPresent;
    state == PTU_S_PDE_RD && memAck && entryPresent;
  endsequence
  sequence sLockedWrite;
    memReq && memWrite && memLock && memWdata[PTU_E_A];
  endsequence

  a_hit_no_walk: assert property (
    (state == PTU_S_LOOK && pagingOn && hitOk && !hitViol)
      |=> state == PTU_S_OPER && memOperand && !memLock
          && memAddr == {$past(tlbFrame), linAddr[PTU_VPN_LSB-1:0]})
    else $error("hit did not go straight to operand access");

  a_miss_dir_read: assert property (
    (state == PTU_S_LOOK && pagingOn && !hitOk)
      |=> memReq && !memWrite && memLock && memAddr == pdeAddr)
    else $error("miss did not read directory entry");

  a_dir_rmw_lock: assert property (
    sDirPresent |=> sLockedWrite)
    else $error("directory flag update not locked write");

  a_table_flags: assert property (
    (state == PTU_S_PTE_RD && memAck && entryPresent && !walkViol)
      |=> sLockedWrite and (memWdata[PTU_E_D] || !accWrite))
    else $error("table entry flags not set");

  a_absent_fault: assert property (
    ((state == PTU_S_PDE_RD || state == PTU_S_PTE_RD) && memAck
      && !entryPresent)
      |=> faultValid && !faultErrorCode[PTU_EC_P] && !memReq)
    else $error("absent entry did not fault");

  a_fault_capture: assert property (
    faultValid |-> faultLinearAddress == linAddr
                   && faultReturnPointer == instrPtr
                   && faultVector == PTU_VEC_PAGE_FAULT)
    else $error("fault capture wrong");

  a_fault_code: assert property (
    faultValid |-> faultErrorCode[PTU_EC_US] == (accUser && !accDesc)
                   && faultErrorCode[PTU_EC_WR] == accWrite)
    else $error("fault code access bits wrong");

  a_flush_cache: assert property (
    flush |=> !tlbAnyValid)
    else $error("cache not flushed");

  a_fill_then_hit: assert property (
    (state == PTU_S_PTE_WR && memAck && !flush) |=> tlbHit)
    else $error("walk result not cached");
endmodule

// >>> bench/ptu_mem_model.sv
`timescale 1ns/100ps
module ptu_mem_model (
  input  wire logic        clk,
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  input  wire logic        memWrite,
  input  wire logic        memLock,
  input  wire logic [31:0] memWdata,
  input  wire logic        slow,
  output logic             memAck,
  output logic [31:0]      memRdata
);
  logic [31:0] mem [logic [31:0]];
  int          nXfer = 0;
  int          nLockWr = 0;
  int          waitCnt = 0;
  initial begin
    memAck = 1'b0;
    memRdata = 32'h0000_0000;
  end
  // Released data bus toggles so a stale read cannot pass
  always @(posedge clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq && !memAck) begin
      if (slow && waitCnt < 2) begin
        waitCnt <= waitCnt + 1;
      end else begin
        waitCnt <= 0;
        memAck <= 1'b1;
        nXfer <= nXfer + 1;
        memRdata <= mem.exists(memAddr) ? mem[memAddr] : 32'h0000_0000;
        if (memWrite) begin
          mem[memAddr] = memWdata;
          if (memLock) nLockWr <= nLockWr + 1;
        end
      end
    end
  end
endmodule

// >>> bench/test_ptu_page_translation_unit.sv
`timescale 1ns/100ps
module test_ptu_page_translation_unit;
  import ptu_pkg::*;
  logic clk, reset_n, hsel, hwrite, hready, hresp, reqValid, reqWrite;
  logic reqUser, reqDescriptor, reqV86, reqReady, doneValid, taskSwitch;
  logic handlerEntry, memReq, memWrite, memLock, memAck, faultValid;
  logic faultNested, slow;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, reqLinAddr, reqInstrPtr, donePhysAddr;
  logic [31:0] taskStateDirBase, memAddr, memWdata, memRdata, faultReturnPointer;
  logic [31:0] r, p;
  logic [7:0]  faultVector;
  logic [15:0] faultErrorCode;
  logic        f;
  int          n_errors = 0;
  int          checked = 0;
  int          x;
  ptu_page_translation_unit i_ptu_page_translation_unit (.clk(clk),
    .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .reqValid(reqValid),
    .reqLinAddr(reqLinAddr), .reqWrite(reqWrite), .reqUser(reqUser),
    .reqDescriptor(reqDescriptor), .reqV86(reqV86), .reqInstrPtr(reqInstrPtr),
    .reqReady(reqReady), .doneValid(doneValid), .donePhysAddr(donePhysAddr),
    .taskSwitch(taskSwitch), .taskStateDirBase(taskStateDirBase),
    .handlerEntry(handlerEntry), .memReq(memReq), .memAddr(memAddr),
    .memWrite(memWrite), .memLock(memLock), .memOperand(), .memWdata(memWdata),
    .memAck(memAck), .memRdata(memRdata), .faultValid(faultValid),
    .faultVector(faultVector), .faultErrorCode(faultErrorCode),
    .faultReturnPointer(faultReturnPointer), .faultNested(faultNested));
  ptu_mem_model i_mem (.clk(clk), .memReq(memReq), .memAddr(memAddr),
    .memWrite(memWrite), .memLock(memLock), .memWdata(memWdata), .slow(slow),
    .memAck(memAck), .memRdata(memRdata));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Mode bits are v86, descriptor, user, write
  task automatic xl(input logic [31:0] a, input logic [3:0] m);
    int n;
    @(posedge clk);
    reqValid <= 1'b1; reqLinAddr <= a; reqInstrPtr <= ~a;
    {reqV86, reqDescriptor, reqUser, reqWrite} <= m;
    do @(negedge clk); while (reqReady !== 1'b1);
    @(posedge clk);
    reqValid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (doneValid !== 1'b1 && faultValid !== 1'b1 && n < 300);
    p = donePhysAddr; f = faultValid;
    if (n >= 300) begin
      n_errors++;
      $display("[FAIL] %0t no answer %h", $time, a);
    end
    @(posedge clk);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
  initial begin
    {reset_n, hsel, hwrite, reqValid, reqWrite, reqUser, reqDescriptor} = '0;
    {reqV86, taskSwitch, handlerEntry, slow, htrans} = '0;
    {haddr, hwdata, reqLinAddr, reqInstrPtr, taskStateDirBase} = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    ahb(0, PTU_OFS_CTRL, 0); chk(r, PTU_CTRL_RESET);
    chk(hresp, PTU_HRESP_OKAY);
    ahb(0, 32'h20, 0); chk(r, 0);
    xl(32'h1234_5678, 0); chk(p, 32'h1234_5678);
    $display("test reset and identity done");
    i_mem.mem[32'h1004] = 32'h2007; i_mem.mem[32'h200C] = 32'h55007;
    ahb(1, PTU_OFS_DIRBASE, 32'h1ABC); ahb(0, PTU_OFS_DIRBASE, 0);
    chk(r, 32'h1000);
    ahb(1, PTU_OFS_CTRL, 1);
    x = i_mem.nLockWr;
    xl(32'h0040_3123, 0); chk(p, 32'h55123);
    chk(i_mem.mem[32'h1004], 32'h2027);
    chk(i_mem.nLockWr - x, 2);
    xl(32'h0040_3123, 1); chk(i_mem.mem[32'h200C], 32'h55067);
    x = i_mem.nXfer;
    xl(32'h0040_3123, 0); chk(i_mem.nXfer - x, 1);
    chk(p, 32'h55123);
    // Table edit needs a flush to be seen
    i_mem.mem[32'h200C] = 32'h66007;
    ahb(1, PTU_OFS_DIRBASE, 32'h1000);
    xl(32'h0040_3123, 0); chk(p, 32'h66123);
    $display("test walk and flush done");
    xl(32'h0080_0010, 4'h3); chk(f, 1);
    chk(faultVector, PTU_VEC_PAGE_FAULT); chk(faultErrorCode, 16'h6);
    chk(faultReturnPointer, ~32'h0080_0010);
    ahb(0, PTU_OFS_FLTADDR, 0); chk(r, 32'h0080_0010);
    xl(32'h0080_0010, 4'h6); chk(faultErrorCode, 16'h0);
    i_mem.mem[32'h2010] = 32'h77005;
    xl(32'h0040_4000, 4'h3); chk(faultErrorCode, 16'h7);
    xl(32'h0040_4000, 4'h2); chk(p, 32'h77000);
    @(posedge clk) handlerEntry <= 1'b1;
    xl(32'h0080_0000, 4'h0); chk(faultNested, 1);
    chk(faultVector, PTU_VEC_PAGE_FAULT); chk(faultErrorCode, 16'h0);
    handlerEntry <= 1'b0;
    $display("test faults done");
    i_mem.mem[32'h3000] = 32'h4007; i_mem.mem[32'h3004] = 32'h4007;
    for (int k = 0; k < 5; k++) i_mem.mem[32'h400C + 32 * k] = 32'h88007 + k * 32'h1000;
    slow <= 1'b1;
    @(posedge clk) begin
      taskSwitch <= 1'b1; taskStateDirBase <= 32'h3000;
    end
    @(posedge clk) taskSwitch <= 1'b0;
    ahb(0, PTU_OFS_DIRBASE, 0); chk(r, 32'h3000);
    xl(32'h0040_3123, 0); chk(p, 32'h88123);
    xl(32'hFFF0_3123, 4'h8); chk(p, 32'h88123);
    for (int k = 1; k < 5; k++) xl(32'h0040_3123 + k * 32'h8000, 0);
    x = i_mem.nXfer;
    xl(32'h0042_3123, 0); chk(p, 32'h8C123);
    chk(i_mem.nXfer - x, 1);
    $display("test task switch and sets done");
    finish_test();
  end
endmodule
